// File: hw/rcc_top.sv
// reset sequencing, coprocessor signalling, nmi and speaker logic
// assumes the host bus status lines and register port are synchronous to
// core_clk_i; all other pins but sys_parity_err_i are asynchronous and pass the synchroniser
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "rcc_cfg.svh"

// Functional notes
// R01 - cold reset asserts host and coprocessor resets
// R02 - decoded shutdown cycle asserts host reset
// R03 - every reset assertion ends 128 clocks after its last trigger
// R04 - write FE to port 64h: fast reset
// R05 - slow keyboard reset waits for halt cycle
// R06 - coprocessor reset on host reset, port F1h
// R07 - bus clock divided, ratio from index 25h
// R08 - ignore-error output pulses low on fault
// R09 - earlier host: pin follows coprocessor fault
// R10 - active-high coprocessor fault interrupt request
// R11 - busy pin level selects host generation
// R12 - tag strap low: busy pin is hit
// R13 - nmi on parity error or channel check
// R14 - speaker from timer 2 and port bit
// R15 - speaker is timer AND port bit
module rcc_top
    import rcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cold_reset_in_n_i,
    input wire logic host_ads_n_i,
    input wire logic host_mio_i,
    input wire logic host_dc_i,
    input wire logic host_wr_i,
    input wire logic [3:0] host_be_n_i,
    input wire logic fpu_fault_in_n_i,
    input wire logic fpu_busy_in_n_i,
    input wire logic tag_line_zero_i,
    input wire logic channel_check_in_n_i,
    input wire logic sys_parity_err_i,
    input wire logic timer_ch2_in_i,
    input wire logic [`RCC_AW-1:0] reg_addr_i,
    input wire logic [`RCC_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`RCC_DW-1:0] reg_rdata_o,
    output logic host_reset_out_o,
    output logic fpu_reset_out_o,
    output logic expansion_bus_clock_o,
    output logic ignore_fpu_fault_n_o,
    output logic fpu_fault_irq_o,
    output logic host_modified_hit_n_o,
    output logic nmi_o,
    output logic speaker_data_out_o,
    output logic irq_o
);

    rcc_core_if core_if ();

    rcc_top_st_t st_q;
    rcc_top_st_t st_d;

    logic [`RCC_SYNC_W-1:0] raw;
    logic cold_act;
    logic fault_act;
    logic busy_lvl;
    logic channel_check_in_n_act;
    logic tmr2;
    logic tag_line_zero;
    logic special_cyc;
    logic shutdown_cyc;
    logic halt_cyc;
    logic kbd_wr;
    logic kbd_now;
    logic f1_wr;
    logic fpu_present;
    logic host_start;
    logic nmi_src;
    logic [`RCC_EV_W-1:0] events;
    logic [`RCC_DW-1:0] state_word;

    assign raw = {tag_line_zero_i, timer_ch2_in_i, channel_check_in_n_i,
                  fpu_busy_in_n_i, fpu_fault_in_n_i, cold_reset_in_n_i};

    rcc_sync3 u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i (rst_n_i),
        .raw_i (raw),
        .core (core_if.sync_mp)
    );

    rcc_clk_div u_div (
        .core_clk_i (core_clk_i),
        .rst_n_i (rst_n_i),
        .core (core_if.div_mp)
    );

    assign core_if.ratio = st_q.cfg25[1:0]; // R07

    always_comb
    begin
        cold_act = ~core_if.level[`RCC_SI_COLD];
        fault_act = ~core_if.level[`RCC_SI_FAULT];
        busy_lvl = core_if.level[`RCC_SI_BUSY];
        channel_check_in_n_act = ~core_if.level[`RCC_SI_CHANNEL_CHECK_IN_N];
        tmr2 = core_if.level[`RCC_SI_TMR2];
        tag_line_zero = core_if.level[`RCC_SI_TAG_LINE_ZERO];

        // special cycles: I/O space, control, write; byte enables say which
        special_cyc = ~host_ads_n_i & ~host_mio_i & ~host_dc_i & host_wr_i;
        shutdown_cyc = special_cyc & (host_be_n_i == `RCC_BE_SHUTDOWN); // R02
        halt_cyc = special_cyc & (host_be_n_i == `RCC_BE_HALT);

        kbd_wr = reg_wr_i & (reg_addr_i == `RCC_IO_KBD) & (reg_wdata_i == `RCC_KBD_CMD); // R04
        kbd_now = (kbd_wr & st_q.cfg20[`RCC_CFG20_FAST_KBD]) | (st_q.kbd_pend & halt_cyc); // R04 R05
        f1_wr = reg_wr_i & (reg_addr_i == `RCC_IO_FPU_RST);
        fpu_present = st_q.cfg20[`RCC_CFG20_FPU_PRES];
        host_start = cold_act | shutdown_cyc | kbd_now; // R01 R02

        nmi_src = sys_parity_err_i | channel_check_in_n_act; // R13

        events = `RCC_EV_ZERO;
        events[`RCC_EV_RST] = host_start & (st_q.host_cnt == `RCC_CNT_ZERO);
        events[`RCC_EV_FAULT] = fault_act & st_q.fault_prev;
        events[`RCC_EV_NMI] = nmi_src & ~st_q.nmi_prev;

        state_word = `RCC_BYTE_ZERO;
        state_word[0] = st_q.host_cnt != `RCC_CNT_ZERO;
        state_word[1] = st_q.fpu_cnt != `RCC_CNT_ZERO;
        state_word[2] = st_q.kbd_pend;
        state_word[3] = st_q.mode == RCC_MODE_EARLIER;
        state_word[4] = st_q.tag_line_zero_strap;

        st_d = st_q;
        st_d.fault_prev = ~fault_act;
        st_d.nmi_prev = nmi_src;

        // host reset counter: reload on any trigger, so it ends 128 clocks after the last
        if (host_start)
        begin
            st_d.host_cnt = `RCC_RST_CYCLES; // R03
        end
        else if (st_q.host_cnt != `RCC_CNT_ZERO)
        begin
            st_d.host_cnt = st_q.host_cnt - `RCC_CNT_ONE; // R03
        end

        if (cold_act | (fpu_present & (host_start | f1_wr)))
        begin
            st_d.fpu_cnt = `RCC_RST_CYCLES; // R01 R06 R03
        end
        else if (st_q.fpu_cnt != `RCC_CNT_ZERO)
        begin
            st_d.fpu_cnt = st_q.fpu_cnt - `RCC_CNT_ONE; // R03
        end

        // a slow keyboard reset waits; a cold reset discards it
        if (cold_act | halt_cyc)
        begin
            st_d.kbd_pend = 1'b0; // R05
        end
        if (kbd_wr & ~st_q.cfg20[`RCC_CFG20_FAST_KBD] & ~cold_act)
        begin
            st_d.kbd_pend = 1'b1; // R05
        end

        // straps are sampled while the cold reset is held and frozen after
        if (cold_act)
        begin
            st_d.mode = busy_lvl ? RCC_MODE_EARLIER : RCC_MODE_LATER; // R11
            st_d.tag_line_zero_strap = tag_line_zero;
        end

        if (st_q.mode == RCC_MODE_EARLIER)
        begin
            st_d.ign_n = ~fault_act; // R09
        end
        else
        begin
            st_d.ign_n = ~(fault_act & st_q.fault_prev); // R08
        end
        st_d.irq13 = fault_act; // R10
        st_d.host_modified_hit_n_n = st_q.tag_line_zero_strap ? 1'b1 : busy_lvl; // R12
        st_d.nmi = nmi_src; // R13
        st_d.spk = tmr2 & st_q.port61[`RCC_SPK_BIT]; // R14 R15

        // register writes
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                `RCC_IO_SPK: st_d.port61 = reg_wdata_i;
                `RCC_CFG_20: st_d.cfg20 = reg_wdata_i;
                `RCC_CFG_25: st_d.cfg25 = reg_wdata_i; // R07
                `RCC_IRQ_EN: st_d.irq_en = reg_wdata_i[`RCC_EV_W-1:0];
                default: st_d.irq_en = st_q.irq_en;
            endcase
        end

        // a new event in the cycle of its clear survives
        st_d.irq_stat = st_q.irq_stat;
        if (reg_wr_i & (reg_addr_i == `RCC_IRQ_CLR))
        begin
            st_d.irq_stat = st_q.irq_stat & ~reg_wdata_i[`RCC_EV_W-1:0];
        end
        st_d.irq_stat = st_d.irq_stat | events;
        st_d.irq = |(st_d.irq_stat & st_d.irq_en);

        // read data stands only in the cycle after the strobe
        st_d.rdata = `RCC_BYTE_ZERO;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `RCC_IO_SPK: st_d.rdata = st_q.port61;
                `RCC_CFG_20: st_d.rdata = st_q.cfg20;
                `RCC_CFG_25: st_d.rdata = st_q.cfg25;
                `RCC_IRQ_STAT: st_d.rdata = {{(`RCC_DW-`RCC_EV_W){1'b0}}, st_q.irq_stat};
                `RCC_IRQ_EN: st_d.rdata = {{(`RCC_DW-`RCC_EV_W){1'b0}}, st_q.irq_en};
                `RCC_STATE: st_d.rdata = state_word;
                default: st_d.rdata = `RCC_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q.cfg20 <= `RCC_CFG20_RST;
            st_q.cfg25 <= `RCC_CFG25_RST;
            st_q.port61 <= `RCC_BYTE_ZERO;
            st_q.irq_stat <= `RCC_EV_ZERO;
            st_q.irq_en <= `RCC_EV_ZERO;
            st_q.host_cnt <= `RCC_RST_CYCLES;
            st_q.fpu_cnt <= `RCC_RST_CYCLES;
            st_q.kbd_pend <= 1'b0;
            st_q.mode <= RCC_MODE_LATER;
            st_q.tag_line_zero_strap <= 1'b1;
            st_q.fault_prev <= 1'b1;
            st_q.nmi_prev <= 1'b0;
            st_q.ign_n <= 1'b1;
            st_q.irq13 <= 1'b0;
            st_q.host_modified_hit_n_n <= 1'b1;
            st_q.nmi <= 1'b0;
            st_q.spk <= 1'b0;
            st_q.irq <= 1'b0;
            st_q.rdata <= `RCC_BYTE_ZERO;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // reset outputs decode the counters directly: high until 128 edges after the last load
    assign host_reset_out_o = st_q.host_cnt != `RCC_CNT_ZERO; // R01 R03
    assign fpu_reset_out_o = st_q.fpu_cnt != `RCC_CNT_ZERO; // R01 R06
    assign expansion_bus_clock_o = core_if.bus_clk; // R07
    assign ignore_fpu_fault_n_o = st_q.ign_n;
    assign fpu_fault_irq_o = st_q.irq13;
    assign host_modified_hit_n_o = st_q.host_modified_hit_n_n;
    assign nmi_o = st_q.nmi;
    assign speaker_data_out_o = st_q.spk;
    assign irq_o = st_q.irq;
    assign reg_rdata_o = st_q.rdata;

endmodule : rcc_top

// File: hw/rcc_cfg.svh
// constants for the reset and coprocessor control block
// assumes inclusion by package and modules; definitions only
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH

`define RCC_AW 10
`define RCC_DW 8
`define RCC_SYNC_W 6
`define RCC_SI_COLD 0
`define RCC_SI_FAULT 1
`define RCC_SI_BUSY 2
`define RCC_SI_CHANNEL_CHECK_IN_N 3
`define RCC_SI_TMR2 4
`define RCC_SI_TAG_LINE_ZERO 5
`define RCC_SYNC_RST 6'h2E

`define RCC_RST_CYCLES 8'h80
`define RCC_CNT_ZERO 8'h00
`define RCC_CNT_ONE 8'h01

`define RCC_IO_KBD 10'h064
`define RCC_IO_SPK 10'h061
`define RCC_IO_FPU_RST 10'h0F1
`define RCC_CFG_20 10'h220
`define RCC_CFG_25 10'h225
`define RCC_IRQ_STAT 10'h300
`define RCC_IRQ_CLR 10'h304
`define RCC_IRQ_EN 10'h308
`define RCC_STATE 10'h30C

`define RCC_KBD_CMD 8'hFE
`define RCC_CFG20_FAST_KBD 1
`define RCC_CFG20_FPU_PRES 2
`define RCC_CFG20_RST 8'h06
`define RCC_CFG25_RST 8'h00
`define RCC_SPK_BIT 1
`define RCC_BYTE_ZERO 8'h00

`define RCC_BE_SHUTDOWN 4'hE
`define RCC_BE_HALT 4'hB

`define RCC_EV_W 3
`define RCC_EV_RST 0
`define RCC_EV_FAULT 1
`define RCC_EV_NMI 2
`define RCC_EV_ZERO 3'h0

`define RCC_DIV_CNT_W 3
`define RCC_DIV_ZERO 3'h0
`define RCC_DIV_ONE 3'h1

`endif

// File: hw/rcc_pkg.sv
// types shared by the reset and coprocessor control modules
// assumes rcc_cfg.svh is on the include path
`include "rcc_cfg.svh"

package rcc_pkg;

    typedef enum logic {RCC_MODE_LATER, RCC_MODE_EARLIER} rcc_host_mode_t;

    typedef struct packed {
        logic [`RCC_SYNC_W-1:0] ff1;
        logic [`RCC_SYNC_W-1:0] ff2;
        logic [`RCC_SYNC_W-1:0] ff3;
        logic [`RCC_SYNC_W-1:0] level;
    } rcc_sync_st_t;

    typedef struct packed {
        logic [`RCC_DIV_CNT_W-1:0] cnt;
        logic bus_clk;
    } rcc_div_st_t;

    typedef struct packed {
        logic [`RCC_DW-1:0] cfg20;
        logic [`RCC_DW-1:0] cfg25;
        logic [`RCC_DW-1:0] port61;
        logic [`RCC_EV_W-1:0] irq_stat;
        logic [`RCC_EV_W-1:0] irq_en;
        logic [`RCC_DW-1:0] host_cnt;
        logic [`RCC_DW-1:0] fpu_cnt;
        logic kbd_pend;
        rcc_host_mode_t mode;
        logic tag_line_zero_strap;
        logic fault_prev;
        logic nmi_prev;
        logic ign_n;
        logic irq13;
        logic host_modified_hit_n_n;
        logic nmi;
        logic spk;
        logic irq;
        logic [`RCC_DW-1:0] rdata;
    } rcc_top_st_t;

endpackage : rcc_pkg

// File: hw/rcc_core_if.sv
// carrier between the top and its synchroniser and clock divider
// assumes all members live on core_clk_i
`timescale 1ns/10ps
`include "rcc_cfg.svh"

interface rcc_core_if;
    logic [`RCC_SYNC_W-1:0] level;
    logic [1:0] ratio;
    logic bus_clk;
    modport sync_mp (output level);
    modport div_mp (input ratio, output bus_clk);
    modport top_mp (input level, input bus_clk, output ratio);
endinterface : rcc_core_if

// File: hw/rcc_sync3.sv
// three-flop synchroniser for the asynchronous pin inputs
// assumes pins may change at any time relative to core_clk_i
`timescale 1ns/10ps
`include "rcc_cfg.svh"

module rcc_sync3
    import rcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [`RCC_SYNC_W-1:0] raw_i,
    rcc_core_if.sync_mp core
);

    rcc_sync_st_t st_q;
    rcc_sync_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.ff1 = raw_i;
        st_d.ff2 = st_q.ff1;
        st_d.ff3 = st_q.ff2;
        // a change counts only once the second and third stage agree
        st_d.level = (st_q.ff2 & st_q.ff3) | (st_q.level & (st_q.ff2 | st_q.ff3));
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= {4{`RCC_SYNC_RST}};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign core.level = st_q.level;

endmodule : rcc_sync3

// File: hw/rcc_clk_div.sv
// expansion bus clock divider, divide by 2, 4, 6 or 8
// assumes the ratio comes from a register on the same clock
`timescale 1ns/10ps
`include "rcc_cfg.svh"

module rcc_clk_div
    import rcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    rcc_core_if.div_mp core
);

    rcc_div_st_t st_q;
    rcc_div_st_t st_d;
    logic [`RCC_DIV_CNT_W-1:0] half_m1;

    always_comb
    begin
        half_m1 = {1'b0, core.ratio};
        st_d = st_q;
        // compare with >= so a smaller ratio written mid-period cannot strand the counter
        if (st_q.cnt >= half_m1)
        begin
            st_d.cnt = `RCC_DIV_ZERO;
            st_d.bus_clk = ~st_q.bus_clk;
        end
        else
        begin
            st_d.cnt = st_q.cnt + `RCC_DIV_ONE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign core.bus_clk = st_q.bus_clk;

endmodule : rcc_clk_div

// File: bench/rcc_host_model.sv
// host processor and coprocessor pins as seen by the control block
// assumes the bench sets the fault and busy levels directly
`timescale 1ns/10ps

module rcc_host_model
(
    input wire logic core_clk_i,
    output logic host_ads_n_o,
    output logic host_mio_o,
    output logic host_dc_o,
    output logic host_wr_o,
    output logic [3:0] host_be_n_o,
    output logic fault_n_o,
    output logic busy_n_o
);
    initial
    begin
        host_ads_n_o = 1'b1;
        {host_mio_o, host_dc_o, host_wr_o} = 3'h6;
        host_be_n_o = 4'hF;
        fault_n_o = 1'b1;
        busy_n_o = 1'b0;
    end

    // one special cycle; between cycles the status lines flip so stale values never look valid
    task automatic cyc(input logic [3:0] be);
        @(posedge core_clk_i);
        host_ads_n_o <= 1'b0;
        {host_mio_o, host_dc_o, host_wr_o} <= 3'h1;
        host_be_n_o <= be;
        @(posedge core_clk_i);
        host_ads_n_o <= 1'b1;
        {host_mio_o, host_dc_o, host_wr_o} <= 3'h6;
        host_be_n_o <= ~be;
    endtask : cyc
endmodule : rcc_host_model

// File: bench/rcc_properties.sv
// pin-level assertions for the reset and coprocessor control block
// assumes it is bound onto rcc_top, one clock domain
`timescale 1ns/10ps
`include "rcc_cfg.svh"

module rcc_properties
    import rcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cold_reset_in_n_i,
    input wire logic host_ads_n_i,
    input wire logic host_mio_i,
    input wire logic host_dc_i,
    input wire logic host_wr_i,
    input wire logic [3:0] host_be_n_i,
    input wire logic fpu_fault_in_n_i,
    input wire logic sys_parity_err_i,
    input wire logic timer_ch2_in_i,
    input wire logic [`RCC_AW-1:0] reg_addr_i,
    input wire logic [`RCC_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic host_reset_out_o,
    input wire logic fpu_reset_out_o,
    input wire logic fpu_fault_irq_o,
    input wire logic nmi_o,
    input wire logic speaker_data_out_o
);
    logic fast_q;
    logic pres_q;
    logic [8:0] hcnt_q;

    // only pins are visible, so the two config bits are shadowed from the writes
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fast_q <= 1'b1;
            pres_q <= 1'b1;
            hcnt_q <= 9'h000;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `RCC_CFG_20)
            begin
                fast_q <= reg_wdata_i[`RCC_CFG20_FAST_KBD];
                pres_q <= reg_wdata_i[`RCC_CFG20_FPU_PRES];
            end
            hcnt_q <= host_reset_out_o ? hcnt_q + 9'h001 : 9'h000;
        end
    end

    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // six samples: three sync stages, the level stage and the counter load
    a_cold_both: assert property (!cold_reset_in_n_i [*6] |-> host_reset_out_o && fpu_reset_out_o)
        else $error("resets not held during cold reset");
    a_shutdown_rst: assert property (!host_ads_n_i && !host_mio_i && !host_dc_i && host_wr_i
        && host_be_n_i == `RCC_BE_SHUTDOWN |=> host_reset_out_o) else $error("no reset on shutdown");
    a_reset_len: assert property ($fell(host_reset_out_o) |-> hcnt_q >= 9'h080)
        else $error("host reset too short");
    a_kbd_fast: assert property (reg_wr_i && reg_addr_i == `RCC_IO_KBD && reg_wdata_i == `RCC_KBD_CMD
        && fast_q |=> host_reset_out_o) else $error("no fast keyboard reset");
    a_port_fpu: assert property (reg_wr_i && reg_addr_i == `RCC_IO_FPU_RST && pres_q |=> fpu_reset_out_o)
        else $error("no coprocessor reset on port write");
    a_fault_irq: assert property ($fell(fpu_fault_in_n_i) ##1 !fpu_fault_in_n_i [*5] |-> fpu_fault_irq_o)
        else $error("no coprocessor fault request");
    a_nmi_parity: assert property (sys_parity_err_i |=> nmi_o)
        else $error("no nmi on parity error");
    a_spk_quiet: assert property (!timer_ch2_in_i [*6] |=> !speaker_data_out_o)
        else $error("speaker active with timer low");
endmodule : rcc_properties

bind rcc_top rcc_properties u_props (.*);

// File: bench/tb.sv
// self-checking bench for the reset and coprocessor control block
// assumes rcc_top, rcc_host_model and the bound checker are compiled
`timescale 1ns/10ps
`include "rcc_cfg.svh"

module tb;
    import rcc_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cold_reset_in_n_i = 1'b0;
    logic tag_line_zero_i = 1'b1;
    logic channel_check_in_n_i = 1'b1;
    logic sys_parity_err_i = 1'b0;
    logic timer_ch2_in_i = 1'b1;
    logic [`RCC_AW-1:0] reg_addr_i = 10'h000;
    logic [`RCC_DW-1:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic host_ads_n_i, host_mio_i, host_dc_i, host_wr_i, fpu_fault_in_n_i, fpu_busy_in_n_i;
    logic [3:0] host_be_n_i;
    logic [`RCC_DW-1:0] reg_rdata_o;
    logic host_reset_out_o, fpu_reset_out_o, expansion_bus_clock_o, ignore_fpu_fault_n_o;
    logic fpu_fault_irq_o, host_modified_hit_n_o, nmi_o, speaker_data_out_o, irq_o;
    logic [7:0] n;
    int failures = 0;
    int comparisons = 0;
    int i;

    always #5 core_clk_i = ~core_clk_i;

    rcc_top dut (.*);
    rcc_host_model u_host (.core_clk_i(core_clk_i), .host_ads_n_o(host_ads_n_i), .host_mio_o(host_mio_i),
        .host_dc_o(host_dc_i), .host_wr_o(host_wr_i), .host_be_n_o(host_be_n_i),
        .fault_n_o(fpu_fault_in_n_i), .busy_n_o(fpu_busy_in_n_i));

    task automatic end_sim(input bit hung);
        if (hung)
            failures++;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask : rdc

    // counts cycles of one reset pulse; a stuck pulse ends the run as a failure
    task automatic meas(input bit f, output logic [7:0] c);
        int k;
        c = 8'h00;
        for (k = 0; k < 400; k++)
        begin
            #1;
            if ((f ? fpu_reset_out_o : host_reset_out_o) === 1'b1)
                c++;
            else if (c != 8'h00)
                break;
            @(posedge core_clk_i);
        end
        if (k == 400)
            end_sim(1'b1);
    endtask : meas

    task automatic half(output logic [7:0] c);
        logic b;
        b = expansion_bus_clock_o;
        c = 8'h00;
        while (expansion_bus_clock_o === b && c < 8'h20)
        begin
            tick(1);
            c++;
        end
        if (c == 8'h20)
            end_sim(1'b1);
    endtask : half

    initial
    begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        tick(4);
        chk({6'h00, host_reset_out_o, fpu_reset_out_o}, 8'h03);
        cold_reset_in_n_i <= 1'b1;
        meas(1'b0, n);
        rdc(`RCC_CFG_20, `RCC_CFG20_RST);
        rdc(`RCC_CFG_25, `RCC_CFG25_RST);
        rdc(10'h3F0, `RCC_BYTE_ZERO);
        $display("test reset done");
        wr(`RCC_IO_KBD, `RCC_KBD_CMD);
        meas(1'b0, n);
        chk(n, `RCC_RST_CYCLES);
        wr(`RCC_IO_FPU_RST, 8'h00);
        meas(1'b1, n);
        chk(n, `RCC_RST_CYCLES);
        u_host.cyc(`RCC_BE_SHUTDOWN);
        #1;
        chk({6'h00, host_reset_out_o, fpu_reset_out_o}, 8'h03);
        meas(1'b0, n);
        chk(n, `RCC_RST_CYCLES);
        wr(`RCC_CFG_20, 8'h04);
        wr(`RCC_IO_KBD, `RCC_KBD_CMD);
        tick(6);
        chk({7'h00, host_reset_out_o}, 8'h00);
        u_host.cyc(`RCC_BE_HALT);
        meas(1'b0, n);
        chk(n, `RCC_RST_CYCLES);
        wr(`RCC_CFG_20, 8'h02);
        u_host.cyc(`RCC_BE_SHUTDOWN);
        #1;
        chk({6'h00, host_reset_out_o, fpu_reset_out_o}, 8'h02);
        meas(1'b0, n);
        wr(`RCC_CFG_20, `RCC_CFG20_RST);
        $display("test resets done");
        for (int r = 0; r < 4; r++)
        begin
            wr(`RCC_CFG_25, r[7:0]);
            tick(4);
            half(n);
            half(n);
            chk(n, r[7:0] + 8'h01);
        end
        $display("test divider done");
        wr(`RCC_IRQ_CLR, 8'h07);
        wr(`RCC_IRQ_EN, 8'h02);
        rdc(`RCC_IRQ_STAT, 8'h00);
        u_host.fault_n_o <= 1'b0;
        for (i = 0; i < 10 && ignore_fpu_fault_n_o !== 1'b0; i++)
            tick(1);
        if (i == 10)
            end_sim(1'b1);
        chk({7'h00, fpu_fault_irq_o}, 8'h01);
        tick(1);
        chk({7'h00, ignore_fpu_fault_n_o}, 8'h01);
        tick(1);
        chk({7'h00, irq_o}, 8'h01);
        wr(`RCC_IRQ_EN, 8'h00);
        tick(1);
        chk({7'h00, irq_o}, 8'h00);
        wr(`RCC_IRQ_EN, 8'h02);
        tick(1);
        chk({7'h00, irq_o}, 8'h01);
        u_host.fault_n_o <= 1'b1;
        wr(`RCC_IRQ_CLR, 8'h02);
        tick(1);
        chk({7'h00, irq_o}, 8'h00);
        rdc(`RCC_IRQ_STAT, 8'h00);
        $display("test fault done");
        @(posedge core_clk_i);
        sys_parity_err_i <= 1'b1;
        @(posedge core_clk_i);
        sys_parity_err_i <= 1'b0;
        #1;
        chk({7'h00, nmi_o}, 8'h01);
        channel_check_in_n_i <= 1'b0;
        tick(6);
        chk({7'h00, nmi_o}, 8'h01);
        channel_check_in_n_i <= 1'b1;
        tick(6);
        chk({7'h00, nmi_o}, 8'h00);
        rdc(`RCC_IRQ_STAT, 8'h04);
        chk({7'h00, speaker_data_out_o}, 8'h00);
        wr(`RCC_IO_SPK, 8'h02);
        tick(6);
        chk({7'h00, speaker_data_out_o}, 8'h01);
        rdc(`RCC_IO_SPK, 8'h02);
        timer_ch2_in_i <= 1'b0;
        tick(6);
        chk({7'h00, speaker_data_out_o}, 8'h00);
        $display("test nmi speaker done");
        u_host.busy_n_o <= 1'b1;
        tag_line_zero_i <= 1'b0;
        cold_reset_in_n_i <= 1'b0;
        tick(8);
        cold_reset_in_n_i <= 1'b1;
        meas(1'b0, n);
        u_host.fault_n_o <= 1'b0;
        tick(8);
        chk({7'h00, ignore_fpu_fault_n_o}, 8'h00);
        u_host.fault_n_o <= 1'b1;
        tick(6);
        chk({7'h00, ignore_fpu_fault_n_o}, 8'h01);
        u_host.busy_n_o <= 1'b0;
        tick(6);
        chk({7'h00, host_modified_hit_n_o}, 8'h00);
        u_host.busy_n_o <= 1'b1;
        tick(6);
        chk({7'h00, host_modified_hit_n_o}, 8'h01);
        rdc(`RCC_STATE, 8'h08);
        rdc(`RCC_IRQ_STAT, 8'h07);
        $display("test earlier mode done");
        end_sim(1'b0);
    end
endmodule : tb
